// file: logic/rst_seq_host.sv
// Decided for this implementation: the APB register port and the address map.
`timescale 1ns/1ps
// Summary of operation
// - Assert reset, then supplies, then clock.
// - Hold reset 100 us after stable clock.
// - Hold reset 100 ms after power.
// - Power down: reset, clock stop, supplies.
// - Power-down input shuts all but monitor.
// - Unused power-down input held low.
// - Global link reset restores link registers.
// - Global link reset only at power-on.
// - Serial bus on pull-up or force bit.
// - Protocol select: high beta, low legacy.
// - Protocol select held high normally.
// - Test inputs: control high, scans low.
// - Sample statics, train within 80 ms.
module rst_seq_host
    import rst_seq_pkg::*;
#(
    parameter int unsigned PWR_WAIT = PWR_STABLE_CYC,
    parameter int unsigned CLK_WAIT = CLK_STABLE_CYC
)(
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        power_good_i,
    input  wire logic        clk_stable_i,
    rst_seq_if.host          link
);

    seq_state_t           state_q;
    logic [CTRL_W-1:0]    ctrl_q;
    logic [CNT_W-1:0]     pwr_cnt_q;
    logic [CNT_W-1:0]     clk_cnt_q;
    logic                 trained_q;
    logic                 apb_wr;
    logic                 addr_ok;
    // One-shot flag: global reset released since power-on
    logic                 global_link_reset_n_done_q;

    // Zero-wait slave; unmapped addresses answer with an error
    // Status is read-only: writes to it are dropped without an error
    assign pready_o  = 1'b1;
    assign addr_ok   = (paddr_i == CTRL_ADDR) || (paddr_i == STATUS_ADDR);
    assign pslverr_o = psel_i && penable_i && !addr_ok;
    assign apb_wr    = psel_i && penable_i && pwrite_i && (paddr_i == CTRL_ADDR);

    // Control register
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            ctrl_q <= CTRL_RESET;
        else if (apb_wr)
        begin
            ctrl_q <= pwdata_i[CTRL_W-1:0];
            if (global_link_reset_n_done_q)
                ctrl_q[CTRL_GLOBAL_LINK_RESET_N_BIT] <= 1'b0;
        end
    end

    // global reset is a one-shot after power-on
    // A runtime pulse would wipe link state that software expects to keep
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            global_link_reset_n_done_q <= 1'b0;
        else if (!ctrl_q[CTRL_GLOBAL_LINK_RESET_N_BIT])
            global_link_reset_n_done_q <= 1'b1;
    end

    // Read data is registered so it is stable in the access phase
    // Unmapped reads return zero
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            prdata_o <= 32'h0000_0000;
        else if (psel_i && !penable_i)
        begin
            prdata_o <= 32'h0000_0000;
            if (paddr_i == CTRL_ADDR)
                prdata_o[CTRL_W-1:0] <= ctrl_q;
            else if (paddr_i == STATUS_ADDR)
            begin
                prdata_o[ST_STATE_LSB +: 3] <= state_q;
                prdata_o[ST_PERST_BIT]      <= link.perst_n;
                prdata_o[ST_PWR_BIT]        <= power_good_i;
                prdata_o[ST_CLK_BIT]        <= clk_stable_i;
                prdata_o[ST_TRAIN_BIT]      <= trained_q;
                prdata_o[ST_CNA_BIT]        <= link.cable_not_active_output;
            end
        end
    end

    // Sequencer: power-up and power-down order
    // Clearing the power request always takes the ordered shutdown path
    // A loss in run falls back to the wait state; only the counter of the lost input is cleared
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            state_q <= SEQ_OFF;
        else
        begin
            case (state_q)
                SEQ_OFF:
                    if (ctrl_q[CTRL_PWR_REQ_BIT])
                        state_q <= SEQ_PWR_ON;
                SEQ_PWR_ON:
                    if (!ctrl_q[CTRL_PWR_REQ_BIT])
                        state_q <= SEQ_DOWN_RST;
                    else if (power_good_i)
                        state_q <= SEQ_CLK_ON;
                SEQ_CLK_ON:
                    if (!ctrl_q[CTRL_PWR_REQ_BIT])
                        state_q <= SEQ_DOWN_RST;
                    else
                        state_q <= SEQ_WAIT;
                SEQ_WAIT:
                    if (!ctrl_q[CTRL_PWR_REQ_BIT])
                        state_q <= SEQ_DOWN_RST;
                    else if (pwr_cnt_q >= PWR_WAIT && clk_cnt_q >= CLK_WAIT)
                        state_q <= SEQ_RUN;
                SEQ_RUN:
                    if (!ctrl_q[CTRL_PWR_REQ_BIT])
                        state_q <= SEQ_DOWN_RST;
                    else if (!power_good_i || !clk_stable_i)
                        state_q <= SEQ_WAIT;
                SEQ_DOWN_RST:
                    state_q <= SEQ_DOWN_CLK;
                SEQ_DOWN_CLK:
                    state_q <= SEQ_OFF;
                default:
                    state_q <= SEQ_OFF;
            endcase
        end
    end

    // waits restart on any loss
    // Counters saturate at the limit, so a long run never wraps around
    // Supply and clock enables gate them too: a monitor that reads good
    // while the rail is still off must not shorten the wait
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            pwr_cnt_q <= '0;
            clk_cnt_q <= '0;
        end
        else
        begin
            if (!power_good_i || !link.supply_en)
                pwr_cnt_q <= '0;
            else if (pwr_cnt_q < PWR_WAIT)
                pwr_cnt_q <= pwr_cnt_q + 1'b1;
            if (!clk_stable_i || !link.refclk_en)
                clk_cnt_q <= '0;
            else if (clk_cnt_q < CLK_WAIT)
                clk_cnt_q <= clk_cnt_q + 1'b1;
        end
    end

    // Training seen flag; set wins over the clear on reset assert
    // Cleared outside run so a read after a restart shows fresh training
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            trained_q <= 1'b0;
        else if (link.training_start)
            trained_q <= 1'b1;
        else if (state_q != SEQ_RUN)
            trained_q <= 1'b0;
    end

    // Pin drive; reset is only released in the run state
    // Supply stays on through both shutdown steps and the clock stops one
    // state earlier, so reset is low before either goes away
    assign link.perst_n   = (state_q == SEQ_RUN);
    assign link.supply_en = (state_q == SEQ_PWR_ON) || (state_q == SEQ_CLK_ON)
                          || (state_q == SEQ_WAIT) || (state_q == SEQ_RUN)
                          || (state_q == SEQ_DOWN_RST) || (state_q == SEQ_DOWN_CLK);
    assign link.refclk_en = (state_q == SEQ_CLK_ON) || (state_q == SEQ_WAIT)
                          || (state_q == SEQ_RUN) || (state_q == SEQ_DOWN_RST);
    // global reset meant as one-time pulse
    assign link.global_link_reset_n = !ctrl_q[CTRL_GLOBAL_LINK_RESET_N_BIT];
    assign link.power_down_input = ctrl_q[CTRL_PD_BIT];
    assign link.phy_link_protocol_select = !ctrl_q[CTRL_LEGACY_BIT];
    // test straps at normal levels
    // Scan paths stay off; nothing in this block can reach them
    assign link.test_mode_control = 1'b1;
    assign link.scan_enable_test  = 1'b0;
    assign link.scan_mode_test    = 1'b0;

endmodule : rst_seq_host

// file: logic/rst_seq_pkg.sv
package rst_seq_pkg;

    // Clock rate in kHz so the cycle counts stay exact integers
    localparam int unsigned CLK_KHZ          = 200000;
    // Clock-stable wait; the printed figure is taken as microseconds
    localparam int unsigned CLK_STABLE_US    = 100;
    localparam int unsigned CLK_STABLE_CYC   = (CLK_STABLE_US * CLK_KHZ + 999) / 1000;
    // Power-good wait in milliseconds
    localparam int unsigned PWR_STABLE_MS    = 100;
    localparam int unsigned PWR_STABLE_CYC   = PWR_STABLE_MS * CLK_KHZ;
    // Longest time from reset release to link training start
    localparam int unsigned TRAIN_LIMIT_MS   = 80;
    localparam int unsigned TRAIN_LIMIT_CYC  = TRAIN_LIMIT_MS * CLK_KHZ;
    // Device starts training this many cycles after strap capture, one cycle after release (well inside the limit)
    localparam int unsigned TRAIN_DELAY_CYC  = 16;

    localparam int CNT_W = 32;

    // Host register map over APB (byte addresses)
    localparam logic [11:0] CTRL_ADDR   = 12'h000;
    localparam logic [11:0] STATUS_ADDR = 12'h004;

    // Control register fields
    localparam int CTRL_PWR_REQ_BIT   = 0;
    localparam int CTRL_PD_BIT        = 1;
    localparam int CTRL_GLOBAL_LINK_RESET_N_BIT      = 2;
    localparam int CTRL_SB_FORCE_BIT  = 3;
    localparam int CTRL_LEGACY_BIT    = 4;
    localparam int CTRL_W             = 5;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h04;

    // Status register fields
    localparam int ST_STATE_LSB    = 0;
    localparam int ST_PERST_BIT    = 3;
    localparam int ST_PWR_BIT      = 4;
    localparam int ST_CLK_BIT      = 5;
    localparam int ST_TRAIN_BIT    = 6;
    localparam int ST_CNA_BIT      = 7;
    localparam int ST_SB_BIT       = 8;

    // Host power sequencer states
    typedef enum logic [2:0] {
        SEQ_OFF       = 3'b000,
        SEQ_PWR_ON    = 3'b001,
        SEQ_CLK_ON    = 3'b010,
        SEQ_WAIT      = 3'b011,
        SEQ_RUN       = 3'b100,
        SEQ_DOWN_RST  = 3'b101,
        SEQ_DOWN_CLK  = 3'b110
    } seq_state_t;

endpackage : rst_seq_pkg

// file: logic/rst_seq_if.sv
`timescale 1ns/1ps
// Pins between the system sequencer and the bridge
interface rst_seq_if;
    logic perst_n;
    logic supply_en;
    logic refclk_en;
    logic global_link_reset_n;
    logic power_down_input;
    logic phy_link_protocol_select;
    logic test_mode_control;
    logic scan_enable_test;
    logic scan_mode_test;
    logic sda_pullup;
    logic cable_not_active_output;
    logic training_start;

    modport host (
        output perst_n, supply_en, refclk_en, global_link_reset_n, power_down_input,
        output phy_link_protocol_select, test_mode_control, scan_enable_test, scan_mode_test,
        input  cable_not_active_output, training_start
    );
    modport dev (
        input  perst_n, supply_en, refclk_en, global_link_reset_n, power_down_input,
        input  phy_link_protocol_select, test_mode_control, scan_enable_test, scan_mode_test,
        input  sda_pullup,
        output cable_not_active_output, training_start
    );
endinterface : rst_seq_if

// file: logic/rst_seq_dev.sv
`timescale 1ns/1ps
// Bridge side: reset response, strap capture and power-down gating
module rst_seq_dev
    import rst_seq_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rstn_i,
    rst_seq_if.dev    link,
    input  wire logic cable_active_i,
    input  wire logic serial_bus_force_detect_i,
    output logic      ctrl_reset_o,
    output logic      link_regs_default_o,
    output logic      beta_mode_o,
    output logic      serial_bus_en_o,
    output logic      core_power_on_o
);

    logic       perst_q;
    logic       straps_valid_q;
    logic [7:0] train_cnt_q;
    logic       train_q;
    logic       cna_q;
    logic       ctrl_rst;

    assign ctrl_rst = !link.perst_n || link.power_down_input;
    assign ctrl_reset_o = ctrl_rst;
    assign link_regs_default_o = !link.global_link_reset_n;
    assign core_power_on_o = !link.power_down_input;
    assign link.training_start = train_q;
    assign link.cable_not_active_output = cna_q;

    // Cable monitor stays alive in power-down
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            cna_q <= 1'b1;
        else
            cna_q <= !cable_active_i;
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            perst_q        <= 1'b0;
            straps_valid_q <= 1'b0;
            beta_mode_o    <= 1'b1;
            serial_bus_en_o <= 1'b0;
        end
        else
        begin
            perst_q <= link.perst_n && !link.power_down_input;
            if (ctrl_rst || !link.global_link_reset_n)
                straps_valid_q <= 1'b0;
            else if (!perst_q)
            begin
                straps_valid_q <= 1'b1;
                beta_mode_o <= link.phy_link_protocol_select;
            end
            serial_bus_en_o <= !ctrl_rst
                            && (link.sda_pullup || serial_bus_force_detect_i);
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            train_cnt_q <= '0;
            train_q     <= 1'b0;
        end
        else if (ctrl_rst || !straps_valid_q)
        begin
            train_cnt_q <= '0;
            train_q     <= 1'b0;
        end
        else if (train_cnt_q < 8'(TRAIN_DELAY_CYC))
        begin
            train_cnt_q <= train_cnt_q + 8'h01;
            train_q     <= (train_cnt_q == 8'(TRAIN_DELAY_CYC - 1));
        end
        else
            train_q <= 1'b0;
    end

endmodule : rst_seq_dev

// file: tb/rst_seq_sva.sv
`timescale 1ns/1ps
// Watches the sequencer pins between the two ends
module rst_seq_sva (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic perst_n,
    input wire logic supply_en,
    input wire logic refclk_en,
    input wire logic power_down_input,
    input wire logic test_mode_control,
    input wire logic scan_enable_test,
    input wire logic scan_mode_test,
    input wire logic training_start
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    // Reset may lift only while supply and clock are both on
    property p_perst_on; perst_n |-> supply_en && refclk_en; endproperty
    property p_clk_on; refclk_en |-> supply_en; endproperty
    property p_perst_wait; $rose(perst_n) |-> $past(supply_en, 8) && $past(refclk_en, 8); endproperty
    // Shutdown order: reset first, clock next, supplies last
    property p_clk_off; $fell(refclk_en) |-> !perst_n; endproperty
    property p_sup_off; $fell(supply_en) |-> !refclk_en && !perst_n; endproperty
    property p_test; test_mode_control && !scan_enable_test && !scan_mode_test; endproperty
    // Training only after a settled release, as a single pulse
    property p_train_cause; training_start |-> $past(perst_n, 16) ##1 !training_start; endproperty
    property p_train_due;
        $rose(perst_n) |-> ##[1:40] (training_start || !perst_n || power_down_input);
    endproperty
    a_perst_on: assert property (p_perst_on) else $error("reset lifted early");
    a_clk_on: assert property (p_clk_on) else $error("clock without supply");
    a_perst_wait: assert property (p_perst_wait) else $error("release too soon");
    a_clk_off: assert property (p_clk_off) else $error("clock stopped in run");
    a_sup_off: assert property (p_sup_off) else $error("supply cut too soon");
    a_test: assert property (p_test) else $error("test pins wrong");
    a_train_cause: assert property (p_train_cause) else $error("stray training");
    a_train_due: assert property (p_train_due) else $error("training late");
    c_release: cover property ($rose(perst_n));
    c_train: cover property (training_start);
    c_shutdown: cover property ($fell(supply_en));
endmodule : rst_seq_sva

// file: tb/bridge_reset_and_strap_sequencing_test.sv
`timescale 1ns/1ps
module bridge_reset_and_strap_sequencing_test;
    import rst_seq_pkg::*;
    localparam int unsigned PWR_W = 50;
    localparam int unsigned CLK_W = 10;
    logic clk_i = 0, rstn_i = 0, psel = 0, penable = 0, pwrite = 0, pg = 0, cs = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, r, s = 32'h74cc;
    logic pready, pslverr, last_err, cable = 0, sbf = 0, sda_pu = 0;
    logic rst_o, lrd_o, beta_o, sb_o, core_o;
    int err_count = 0, checks_done = 0, n, ctrl_m = int'(CTRL_RESET), global_link_reset_n_off = 0;
    rst_seq_if link ();
    assign link.sda_pullup = sda_pu;
    rst_seq_host #(.PWR_WAIT(PWR_W), .CLK_WAIT(CLK_W)) u_rst_seq_host (.clk_i(clk_i),
        .rstn_i(rstn_i), .paddr_i(paddr), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .power_good_i(pg), .clk_stable_i(cs), .link(link));
    rst_seq_dev u_rst_seq_dev (.clk_i(clk_i), .rstn_i(rstn_i), .link(link),
        .cable_active_i(cable), .serial_bus_force_detect_i(sbf), .ctrl_reset_o(rst_o),
        .link_regs_default_o(lrd_o), .beta_mode_o(beta_o), .serial_bus_en_o(sb_o),
        .core_power_on_o(core_o));
    rst_seq_sva u_rst_seq_sva (.clk_i(clk_i), .rstn_i(rstn_i), .perst_n(link.perst_n),
        .supply_en(link.supply_en), .refclk_en(link.refclk_en),
        .power_down_input(link.power_down_input), .test_mode_control(link.test_mode_control),
        .scan_enable_test(link.scan_enable_test), .scan_mode_test(link.scan_mode_test),
        .training_start(link.training_start));
    // Free-running 200 MHz clock
    initial
    begin
        forever #2.5 clk_i = ~clk_i;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // One APB transfer; held until pready is seen, giving up after 50 cycles
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_i);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk_i);
        penable <= 1;
        do begin @(posedge clk_i); k++; end while (pready !== 1'b1 && k < 50);
        if (k >= 50) begin err_count++; stop_test(); end
        r = prdata;
        last_err = pslverr;
        psel <= 0;
        penable <= 0;
        // once released, the global reset bit cannot be set again
        if (w && a == CTRL_ADDR) ctrl_m = global_link_reset_n_off ? d & 32'h1b : d & 32'h1f;
        if (ctrl_m[CTRL_GLOBAL_LINK_RESET_N_BIT] == 0) global_link_reset_n_off = 1;
    endtask : apb
    // Waits for reset release, a training pulse or supply off, counting cycles
    task automatic wait_on(input int sel, input int lim);
        n = 0;
        while (!(sel == 0 ? link.perst_n === 1'b1 : sel == 1 ? link.training_start === 1'b1
                 : link.supply_en === 1'b0))
        begin
            @(posedge clk_i); #1; n++;
            if (n > lim) begin err_count++; stop_test(); end
        end
    endtask : wait_on
    // Power up from off and check the release spacing and training
    task automatic power_up(input int unsigned d);
        apb(1, CTRL_ADDR, d);
        wait_on(0, 400);
        chk(32'(n >= PWR_W), 1);
        wait_on(1, 40);
        apb(0, STATUS_ADDR, 0);
        chk(r[2:0], SEQ_RUN);
        chk(r[ST_PERST_BIT], 1);
        chk(r[ST_TRAIN_BIT], 1);
        chk(beta_o, !ctrl_m[4]);
    endtask : power_up
    initial
    begin
        repeat (12) @(posedge clk_i);
        rstn_i <= 1;
        apb(0, CTRL_ADDR, 0);
        chk(r, CTRL_RESET);
        chk(lrd_o, 1);
        apb(0, 12'h0f0, 0);
        chk(last_err, 1);
        $display("test reset done");
        pg <= 1; cs <= 1;
        power_up(1);
        chk(lrd_o, 0);
        chk(rst_o, 0);
        chk(link.phy_link_protocol_select, 1);
        @(posedge clk_i);
        cs <= 0;
        repeat (3) @(posedge clk_i);
        #1 chk(link.perst_n, 0);
        chk(rst_o, 1);
        @(posedge clk_i);
        cs <= 1;
        wait_on(0, 100);
        chk(32'(n >= CLK_W), 1);
        $display("test power up done");
        for (int i = 0; i < 8; i++)
        begin
            @(posedge clk_i);
            s = lfsr(s);
            cable <= s[0]; sda_pu <= s[1]; sbf <= s[2];
            repeat (3) @(posedge clk_i);
            #1 chk(link.cable_not_active_output, !s[0]);
            chk(sb_o, s[1] | s[2]);
        end
        apb(1, CTRL_ADDR, 32'h07);
        #1 chk(core_o, 0);
        chk(rst_o, 1);
        chk(lrd_o, 0);
        apb(0, CTRL_ADDR, 0);
        chk(r, ctrl_m);
        apb(1, CTRL_ADDR, 1);
        #1 chk(link.power_down_input, 0);
        $display("test power down input done");
        apb(1, CTRL_ADDR, 32'h10);
        wait_on(2, 20);
        apb(0, CTRL_ADDR, 0);
        chk(r, ctrl_m);
        chk(link.phy_link_protocol_select, 0);
        power_up(32'h11);
        $display("test legacy restart done");
        stop_test();
    end
endmodule : bridge_reset_and_strap_sequencing_test
